// ---- rpc_params.svh ----
// rpc_params.svh: register map, field positions, reset values, counts
// assumes inclusion by bare name from the pin control files
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define RPC_AW          4
`define RPC_DW          8

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPC_ADDR_CTRL   4'h0
`define RPC_ADDR_DIR    4'h1
`define RPC_ADDR_OUT    4'h2
`define RPC_ADDR_IN     4'h3
`define RPC_ADDR_STAT   4'h4
`define RPC_ADDR_IEN    4'h5
`define RPC_ADDR_ICLR   4'h6
`define RPC_ADDR_BOOT   4'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define RPC_CTRL_EDGE   0
`define RPC_CTRL_RELAX  1
`define RPC_GPIO_B2     0
`define RPC_GPIO_B3     1
`define RPC_EV_IRQ      0
`define RPC_EV_RDONE    1
`define RPC_BOOT_MODE   0
`define RPC_BOOT_CORE   1

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define RPC_REG_RST     8'h00
`define RPC_SYNC_W      6
`define RPC_SYNC_RST    6'h01
`define RPC_STRETCH_DEF 64
`define RPC_CNT_W       16

`endif

// ---- rpc_pkg.sv ----
// rpc_pkg.sv: types for the reset and interrupt pin control block
// assumes rpc_params.svh is reachable by include path
package rpc_pkg;

	// ----------------------------------------
	// internal reset sequence
	// ----------------------------------------
	typedef enum logic [1:0] {
		RPC_HOLD    = 2'b00,
		RPC_STRETCH = 2'b01,
		RPC_RUN     = 2'b10
	} rpc_rst_state_t;

endpackage

// ---- rpc_sync3.sv ----
// rpc_sync3.sv: three-stage pin synchroniser with agreement filter
// assumes one clock; inputs come from pins outside the mclk domain
`timescale 1ns/1ps
module rpc_sync3 #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          reset,
	// pins and filtered levels
	input  wire logic [W-1:0]  pinIn,
	output logic      [W-1:0]  stableOut
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// ----------------------------------------
	// stages; only s2 reads s1
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			s1_reg <= pinIn;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// ----------------------------------------
	// change counts only when stages 2 and 3 agree
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			stableOut <= RST_VAL;
		end else begin
			stableOut <= (s2_reg & ~(s2_reg ^ s3_reg)) | (stableOut & (s2_reg ^ s3_reg));
		end
	end

endmodule

// ---- rpc_reset_irq_pin_control.sv ----
// rpc_reset_irq_pin_control.sv: reset sequencer, interrupt pin, pin states
// assumes one mclk domain, a plain register port and pins sampled here
//
// Overview of operation
// - interrupt pin synchronised before any use
// - interrupt selectable level or falling edge
// - reset pin low holds core and control registers reset, not debug
// - internal reset stretched, released on clock
// - reset pin alone leaves debug logic running
// - six pulse outputs tri-stated during reset
// - oscillator output driven, other pins inputs
// - relaxation oscillator frees both oscillator pins
// - each shared port pin has direction
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`include "rpc_params.svh"
module rpc_reset_irq_pin_control
	import rpc_pkg::*;
#(
	parameter int STRETCH_CYCLES = `RPC_STRETCH_DEF,
	parameter int PWM_N          = 6
) (
	// clock and system reset
	input  wire logic               mclk,
	input  wire logic               reset,
	// register port
	input  wire logic [`RPC_AW-1:0] regAddr,
	input  wire logic [`RPC_DW-1:0] regWdata,
	input  wire logic               regWrite,
	input  wire logic               regRead,
	output logic      [`RPC_DW-1:0] regRdata,
	// control pins
	input  wire logic               ext_irq_in,
	input  wire logic               hwResetN,
	input  wire logic               trstN,
	input  wire logic               boot_mode_pin,
	// oscillator input pin, shared with port bit 2
	input  wire logic               osc_in_pin,
	output logic                    port_b_bit2,
	output logic                    port_b_bit2OeN,
	// oscillator output pin, shared with port bit 3
	input  wire logic               port_b_bit3,
	output logic                    osc_out_pin,
	output logic                    osc_out_pinOeN,
	// pulse outputs
	input  wire logic [PWM_N-1:0]   pwmDrive,
	output logic      [PWM_N-1:0]   pwm_outputs,
	output logic      [PWM_N-1:0]   pwmOeN,
	// oscillator amplifier drive
	input  wire logic               oscAmpDrive,
	// core side
	output logic                    coreResetOut,
	output logic                    dbgResetOut,
	output logic                    bootMode,
	output logic                    irqReq,
	output logic                    intr
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [`RPC_SYNC_W-1:0] syncIn;
	logic [`RPC_SYNC_W-1:0] syncOut;
	logic                   irqLevel;
	logic                   hwRstSync;
	logic                   trstSync;
	logic                   bootSync;
	logic                   b2Sync;
	logic                   b3Sync;
	rpc_rst_state_t         rstState_reg;
	rpc_rst_state_t         rstState_next;
	logic [`RPC_CNT_W-1:0]  stretchCnt_reg;
	logic                   bootMode_reg;
	logic                   coreRst_reg;
	logic                   regRst;
	logic [`RPC_DW-1:0]     ctrl_reg;
	logic [`RPC_DW-1:0]     dir_reg;
	logic [`RPC_DW-1:0]     out_reg;
	logic [`RPC_DW-1:0]     stat_reg;
	logic [`RPC_DW-1:0]     ien_reg;
	logic [`RPC_DW-1:0]     rdata_reg;
	logic [`RPC_DW-1:0]     rdata_next;
	logic [`RPC_DW-1:0]     events;
	logic [`RPC_DW-1:0]     clrMask;
	logic                   irqLevelPrev_reg;
	logic                   irqFall;
	logic                   irqReq_reg;
	logic                   edgeMode;
	logic                   relaxSel;
	logic                   b2Gpio;
	logic                   b3Gpio;
	logic [PWM_N-1:0]       pwm_reg;
	logic                   oscOut_reg;
	logic                   b2Out_reg;

	localparam logic [`RPC_CNT_W-1:0] STRETCH_LAST = `RPC_CNT_W'(STRETCH_CYCLES - 1);

	function automatic logic hit(input logic [`RPC_AW-1:0] a, input logic [`RPC_AW-1:0] off);
		hit = (a == off);
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign syncIn = {port_b_bit3, osc_in_pin, boot_mode_pin, trstN, hwResetN, ext_irq_in};

	rpc_sync3 #(
		.W       (`RPC_SYNC_W),
		.RST_VAL (`RPC_SYNC_RST)
	) u_sync (
		.mclk      (mclk),
		.reset     (reset),
		.pinIn     (syncIn),
		.stableOut (syncOut)
	);

	assign irqLevel  = syncOut[0];
	assign hwRstSync = syncOut[1];
	assign trstSync  = syncOut[2];
	assign bootSync  = syncOut[3];
	assign b2Sync    = syncOut[4];
	assign b3Sync    = syncOut[5];

	// ----------------------------------------
	// internal reset sequence
	// ----------------------------------------
	always_comb begin
		rstState_next = rstState_reg;
		unique case (rstState_reg)
			RPC_HOLD: begin
				if (hwRstSync) begin
					rstState_next = RPC_STRETCH;
				end
			end
			RPC_STRETCH: begin
				if (!hwRstSync) begin
					rstState_next = RPC_HOLD;
				end else if (stretchCnt_reg == STRETCH_LAST) begin
					rstState_next = RPC_RUN;
				end
			end
			RPC_RUN: begin
				if (!hwRstSync) begin
					rstState_next = RPC_HOLD;
				end
			end
			default: begin
				rstState_next = RPC_HOLD;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rstState_reg <= RPC_HOLD;
		end else begin
			rstState_reg <= rstState_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || rstState_reg != RPC_STRETCH) begin
			stretchCnt_reg <= '0;
		end else begin
			stretchCnt_reg <= stretchCnt_reg + `RPC_CNT_W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			coreRst_reg <= 1'b1;
		end else begin
			coreRst_reg <= (rstState_next != RPC_RUN);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			bootMode_reg <= 1'b0;
		end else if (rstState_reg == RPC_HOLD && hwRstSync) begin
			bootMode_reg <= bootSync;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			dbgResetOut <= 1'b1;
		end else begin
			dbgResetOut <= !trstSync;
		end
	end

	assign coreResetOut = coreRst_reg;
	assign bootMode     = bootMode_reg;
	assign regRst       = reset || coreRst_reg;

	// ----------------------------------------
	// register port
	// ----------------------------------------
	assign edgeMode = ctrl_reg[`RPC_CTRL_EDGE];
	assign relaxSel = ctrl_reg[`RPC_CTRL_RELAX];

	always_ff @(posedge mclk) begin
		if (regRst) begin
			ctrl_reg <= `RPC_REG_RST;
		end else if (regWrite && hit(regAddr, `RPC_ADDR_CTRL)) begin
			ctrl_reg <= regWdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (regRst) begin
			dir_reg <= `RPC_REG_RST;
		end else if (regWrite && hit(regAddr, `RPC_ADDR_DIR)) begin
			dir_reg <= regWdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (regRst) begin
			out_reg <= `RPC_REG_RST;
		end else if (regWrite && hit(regAddr, `RPC_ADDR_OUT)) begin
			out_reg <= regWdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (regRst) begin
			ien_reg <= `RPC_REG_RST;
		end else if (regWrite && hit(regAddr, `RPC_ADDR_IEN)) begin
			ien_reg <= regWdata;
		end
	end

	always_comb begin
		rdata_next = '0;
		unique case (regAddr)
			`RPC_ADDR_CTRL: rdata_next = ctrl_reg;
			`RPC_ADDR_DIR:  rdata_next = dir_reg;
			`RPC_ADDR_OUT:  rdata_next = out_reg;
			`RPC_ADDR_STAT: rdata_next = stat_reg;
			`RPC_ADDR_IEN:  rdata_next = ien_reg;
			`RPC_ADDR_IN: begin
				rdata_next[`RPC_GPIO_B2] = b2Sync;
				rdata_next[`RPC_GPIO_B3] = b3Sync;
			end
			`RPC_ADDR_BOOT: begin
				rdata_next[`RPC_BOOT_MODE] = bootMode_reg;
				rdata_next[`RPC_BOOT_CORE] = coreRst_reg;
			end
			default: rdata_next = '0;
		endcase
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_reg <= '0;
		end else if (regRead) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= '0;
		end
	end

	assign regRdata = rdata_reg;

	// ----------------------------------------
	// interrupt pin and events
	// ----------------------------------------
	assign irqFall = irqLevelPrev_reg && !irqLevel;

	always_ff @(posedge mclk) begin
		if (regRst) begin
			irqLevelPrev_reg <= 1'b1;
		end else begin
			irqLevelPrev_reg <= irqLevel;
		end
	end

	always_ff @(posedge mclk) begin
		if (regRst) begin
			irqReq_reg <= 1'b0;
		end else begin
			irqReq_reg <= edgeMode ? irqFall : !irqLevel;
		end
	end

	assign irqReq = irqReq_reg;

	always_comb begin
		events = '0;
		events[`RPC_EV_IRQ]   = !coreRst_reg && (edgeMode ? irqFall : !irqLevel);
		events[`RPC_EV_RDONE] = (rstState_reg == RPC_STRETCH) && (rstState_next == RPC_RUN);
		clrMask = (regWrite && hit(regAddr, `RPC_ADDR_ICLR)) ? regWdata : '0;
	end

	// set beats a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			stat_reg <= `RPC_REG_RST;
		end else begin
			stat_reg <= (stat_reg & ~clrMask) | events;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			intr <= 1'b0;
		end else begin
			intr <= |(((stat_reg & ~clrMask) | events) & ien_reg);
		end
	end

	// ----------------------------------------
	// pin states
	// ----------------------------------------
	assign b2Gpio = !coreRst_reg && relaxSel && dir_reg[`RPC_GPIO_B2];
	assign b3Gpio = !coreRst_reg && relaxSel && dir_reg[`RPC_GPIO_B3];

	assign pwmOeN = coreRst_reg ? '1 : '0;

	always_ff @(posedge mclk) begin
		if (regRst) begin
			pwm_reg <= '0;
		end else begin
			pwm_reg <= pwmDrive;
		end
	end

	assign pwm_outputs = pwm_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			oscOut_reg <= 1'b0;
			b2Out_reg  <= 1'b0;
		end else begin
			oscOut_reg <= b3Gpio ? out_reg[`RPC_GPIO_B3] : oscAmpDrive;
			b2Out_reg  <= b2Gpio && out_reg[`RPC_GPIO_B2];
		end
	end

	assign osc_out_pinOeN = relaxSel && !coreRst_reg && !dir_reg[`RPC_GPIO_B3];
	assign osc_out_pin    = oscOut_reg;
	assign port_b_bit2OeN = !b2Gpio;
	assign port_b_bit2    = b2Out_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	property p_pwmTri;
		coreResetOut |-> (pwmOeN == '1);
	endproperty
	a_pwmTri: assert property (p_pwmTri) else $error("pulse pins driven in reset");

	property p_hold;
		(rstState_reg == RPC_HOLD) |=> coreResetOut;
	endproperty
	a_hold: assert property (p_hold) else $error("core left reset while held");

	property p_stretch;
		$fell(coreResetOut) |-> $past(stretchCnt_reg) == STRETCH_LAST;
	endproperty
	a_stretch: assert property (p_stretch) else $error("reset stretch length wrong");

	property p_boot;
		(rstState_reg == RPC_HOLD && hwRstSync) |=> bootMode == $past(bootSync);
	endproperty
	a_boot: assert property (p_boot) else $error("boot level not captured");

	property p_sync;
		$changed(irqLevel) |-> irqLevel == $past(ext_irq_in, 3) && irqLevel == $past(ext_irq_in, 4);
	endproperty
	a_sync: assert property (p_sync) else $error("interrupt pin not synchronised");

	property p_edge;
		(edgeMode && irqFall && !coreResetOut) |=> irqReq ##1 !irqReq;
	endproperty
	a_edge: assert property (p_edge) else $error("edge request not one pulse");

	property p_osc;
		coreResetOut |-> !osc_out_pinOeN && port_b_bit2OeN;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator pins wrong in reset");

	property p_gpio;
		(!coreResetOut && relaxSel && dir_reg[`RPC_GPIO_B2]) |-> !port_b_bit2OeN;
	endproperty
	a_gpio: assert property (p_gpio) else $error("port bit 2 not driven as output");

	property p_debug;
		(trstSync && !hwRstSync) |=> !dbgResetOut;
	endproperty
	a_debug: assert property (p_debug) else $error("debug reset by reset pin");

	c_release: cover property ($fell(coreResetOut));
	c_edgeIrq: cover property (edgeMode && irqReq);
	c_gpioOut: cover property (!port_b_bit2OeN);
	c_intr:    cover property (intr);

endmodule

// ---- rpc_board_model.sv ----
// rpc_board_model.sv: board reset source and interrupt requester
// assumes the bench calls its tasks; pins move just after mclk rises
`timescale 1ns/1ps
module rpc_board_model (
	// clock
	input  wire logic mclk,
	// pins toward the controller
	output logic      hwResetN,
	output logic      trstN,
	output logic      boot_mode_pin,
	output logic      ext_irq_in
);
	// ----
	// power-up state
	// ----
	// both resets low from power-up, request idle high
	initial begin
		hwResetN      = 1'b0;
		trstN         = 1'b0;
		boot_mode_pin = 1'b0;
		ext_irq_in    = 1'b1;
	end

	// ----
	// board actions
	// ----
	// joint or lone reset
	task automatic board_reset(input logic full, input logic boot, input int len);
		@(posedge mclk);
		hwResetN      <= 1'b0;
		trstN         <= ~full;
		boot_mode_pin <= boot;
		repeat (len) @(posedge mclk);
		hwResetN <= 1'b1;
		trstN    <= 1'b1;
	endtask

	// request held low for len cycles, then released
	task automatic irq_low(input int len);
		@(posedge mclk);
		ext_irq_in <= 1'b0;
		repeat (len) @(posedge mclk);
		ext_irq_in <= 1'b1;
	endtask
endmodule

// ---- rpc_reset_irq_pin_control_test.sv ----
// rpc_reset_irq_pin_control_test.sv: self-checking bench for the pin control block
// assumes rpc_board_model drives the board pins; one mclk domain
`timescale 1ns/1ps
`include "rpc_params.svh"
module rpc_reset_irq_pin_control_test
	import rpc_pkg::*;
;
	// ----
	// signals
	// ----
	// short stretch keeps the run brief
	localparam int STR = 4;
	typedef struct packed {
		logic       wr;
		logic [3:0] a;
		logic [7:0] d;
	} rpc_row_t;
	logic             mclk;
	logic             reset;
	logic [3:0]       regAddr;
	logic [7:0]       regWdata;
	logic             regWrite;
	logic             regRead;
	logic [7:0]       regRdata;
	logic             ext_irq_in;
	logic             hwResetN;
	logic             trstN;
	logic             boot_mode_pin;
	logic             osc_in_pin;
	logic             port_b_bit2;
	logic             port_b_bit2OeN;
	logic             port_b_bit3;
	logic             osc_out_pin;
	logic             osc_out_pinOeN;
	logic [5:0]       pwmDrive;
	logic [5:0]       pwm_outputs;
	logic [5:0]       pwmOeN;
	logic             oscAmpDrive;
	logic             coreResetOut;
	logic             dbgResetOut;
	logic             bootMode;
	logic             irqReq;
	logic             intr;
	int               error_cnt = 0;
	int               checked = 0;
	int               c;
	int               f;
	rpc_row_t         rows [16] = '{
		'{1'b1, 4'h0, 8'h03}, '{1'b0, 4'h0, 8'h03}, '{1'b1, 4'h1, 8'h03}, '{1'b0, 4'h1, 8'h03},
		'{1'b1, 4'h2, 8'h01}, '{1'b0, 4'h2, 8'h01}, '{1'b1, 4'h4, 8'hFF}, '{1'b0, 4'h4, 8'h02},
		'{1'b0, 4'h7, 8'h01}, '{1'b1, 4'h8, 8'h55}, '{1'b0, 4'h8, 8'h00}, '{1'b0, 4'h6, 8'h00},
		'{1'b1, 4'h5, 8'h01}, '{1'b0, 4'h5, 8'h01}, '{1'b1, 4'h3, 8'hFF}, '{1'b0, 4'h3, 8'h01}};

	// released pins read the opposite of what the port would drive
	assign osc_in_pin  = port_b_bit2OeN ? 1'b0 : port_b_bit2;
	assign port_b_bit3 = osc_out_pinOeN ? 1'b1 : osc_out_pin;

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	rpc_board_model u_board (.mclk(mclk), .hwResetN(hwResetN), .trstN(trstN),
		.boot_mode_pin(boot_mode_pin), .ext_irq_in(ext_irq_in));

	rpc_reset_irq_pin_control #(.STRETCH_CYCLES(STR), .PWM_N(6)) u_dut (
		.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.ext_irq_in(ext_irq_in), .hwResetN(hwResetN), .trstN(trstN),
		.boot_mode_pin(boot_mode_pin), .osc_in_pin(osc_in_pin), .port_b_bit2(port_b_bit2),
		.port_b_bit2OeN(port_b_bit2OeN), .port_b_bit3(port_b_bit3),
		.osc_out_pin(osc_out_pin), .osc_out_pinOeN(osc_out_pinOeN), .pwmDrive(pwmDrive),
		.pwm_outputs(pwm_outputs), .pwmOeN(pwmOeN), .oscAmpDrive(oscAmpDrive),
		.coreResetOut(coreResetOut), .dbgResetOut(dbgResetOut), .bootMode(bootMode),
		.irqReq(irqReq), .intr(intr));

	// ----
	// tasks
	// ----
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		chkv({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		chkv(regRdata, e);
	endtask

	task automatic irq_run(input int len, output int cnt, output int first);
		cnt   = 0;
		first = -1;
		fork
			u_board.irq_low(len);
		join_none
		for (int i = 0; i < 24; i++) begin
			@(posedge mclk);
			#1;
			if (irqReq === 1'b1) begin
				if (first < 0)
					first = i;
				cnt++;
			end
		end
	endtask

	task automatic do_reset(input logic full, input logic boot);
		int n;
		fork
			u_board.board_reset(full, boot, 12);
		join_none
		repeat (8) @(posedge mclk);
		#1;
		chkb(coreResetOut, 1'b1);
		chkb(dbgResetOut, full);
		chkv(8'(pwmOeN), 8'h3F);
		chkb(osc_out_pinOeN, 1'b0);
		chkb(osc_out_pin, oscAmpDrive);
		chkb(port_b_bit2OeN, 1'b1);
		rd(`RPC_ADDR_CTRL, 8'h00);
		wr(`RPC_ADDR_CTRL, 8'h03);
		// board lets both pins go on this edge
		@(posedge mclk);
		n = 0;
		while (coreResetOut !== 1'b0 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 200) begin
			error_cnt++;
			give_verdict();
		end
		chkb(n inside {[STR+3:STR+7]}, 1'b1);
		chkb(bootMode, boot);
		rd(`RPC_ADDR_CTRL, 8'h00);
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		reset       = 1'b1;
		regAddr     = 4'h0;
		regWdata    = 8'h00;
		regWrite    = 1'b0;
		regRead     = 1'b0;
		pwmDrive    = 6'h00;
		oscAmpDrive = 1'b1;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		do_reset(1'b1, 1'b1);
		$display("test bring-up done");
		@(posedge mclk);
		pwmDrive <= 6'h2A;
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			else
				rd(rows[i].a, rows[i].d);
		end
		chkb(port_b_bit2OeN, 1'b0);
		chkb(port_b_bit2, 1'b1);
		chkb(osc_out_pinOeN, 1'b0);
		chkb(osc_out_pin, 1'b0);
		chkv(8'(pwmOeN), 8'h00);
		chkv(8'(pwm_outputs), 8'h2A);
		// both shared pins back to inputs; let the synchronisers settle
		wr(`RPC_ADDR_DIR, 8'h00);
		repeat (6) @(posedge mclk);
		#1;
		chkb(osc_out_pinOeN, 1'b1);
		chkb(port_b_bit2OeN, 1'b1);
		rd(`RPC_ADDR_IN, 8'h02);
		$display("test registers and pins done");
		irq_run(6, c, f);
		chkb(c == 1, 1'b1);
		chkb(f inside {[3:8]}, 1'b1);
		chkb(intr, 1'b1);
		rd(`RPC_ADDR_STAT, 8'h03);
		wr(`RPC_ADDR_ICLR, 8'h01);
		rd(`RPC_ADDR_STAT, 8'h02);
		chkb(intr, 1'b0);
		wr(`RPC_ADDR_CTRL, 8'h02);
		irq_run(6, c, f);
		chkb(c inside {[4:8]}, 1'b1);
		wr(`RPC_ADDR_IEN, 8'h00);
		wr(`RPC_ADDR_ICLR, 8'h01);
		irq_run(6, c, f);
		rd(`RPC_ADDR_STAT, 8'h03);
		chkb(intr, 1'b0);
		$display("test interrupt done");
		// low amplifier level shows the pin really follows it
		@(posedge mclk);
		oscAmpDrive <= 1'b0;
		do_reset(1'b0, 1'b0);
		$display("test debug reset done");
		give_verdict();
	end
endmodule
